/* File: design/dma_add_stage.sv */
`timescale 1ns/100ps
// first-stage adder/subtractor fed by two multiplier lanes only
module dma_add_stage (
	input  wire logic [dma_pkg::PROD_W-1:0] p0,
	input  wire logic [dma_pkg::PROD_W-1:0] p1,
	input  wire logic                       pSigned,
	input  wire logic                       nine,
	input  wire logic                       subLo,
	input  wire logic                       subHi,
	output logic      [dma_pkg::RES_W-1:0]  sum
);
	import dma_pkg::*;

	logic [RES_W-1:0]  full;
	logic [HSUM_W-1:0] lo;
	logic [HSUM_W-1:0] hi;

	function automatic logic [RES_W-1:0] ext36(input logic [PROD_W-1:0] p, input logic s);
		return {{(RES_W-PROD_W){s & p[PROD_W-1]}}, p};
	endfunction

	function automatic logic [HSUM_W-1:0] ext18(input logic [HPROD_W-1:0] p, input logic s);
		return {s & p[HPROD_W-1], p};
	endfunction

	// subtraction order is fixed: first lane minus second lane
	always_comb begin
		full = subLo ? ext36(p0, pSigned) - ext36(p1, pSigned)  // RULE20
		             : ext36(p0, pSigned) + ext36(p1, pSigned); // RULE4
		lo   = subLo ? ext18(p0[HPROD_W-1:0], pSigned) - ext18(p1[HPROD_W-1:0], pSigned)
		             : ext18(p0[HPROD_W-1:0], pSigned) + ext18(p1[HPROD_W-1:0], pSigned);
		hi   = subHi ? ext18(p0[PROD_W-1:HPROD_W], pSigned) - ext18(p1[PROD_W-1:HPROD_W], pSigned)
		             : ext18(p0[PROD_W-1:HPROD_W], pSigned) + ext18(p1[PROD_W-1:HPROD_W], pSigned);
		sum  = nine ? {hi, lo} : full; // RULE3
	end

endmodule

/* File: design/dma_mult_add.sv */
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module dma_mult_add (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          ce,
	input  wire logic [dma_pkg::ADDR_W-1:0]    regAddr,
	input  wire logic [dma_pkg::DATA_W-1:0]    regWrData,
	input  wire logic                          regWr,
	input  wire logic                          regRd,
	output logic      [dma_pkg::DATA_W-1:0]    regRdData,
	input  wire logic                          inValid,
	input  wire dma_pkg::dma_ops_t             opIn,
	input  wire logic                          signA,
	input  wire logic                          signB,
	input  wire logic [dma_pkg::LANES-1:0]     addSub,
	output logic      [dma_pkg::OP_W-1:0]      shiftOut,
	output logic                               outValid,
	output dma_pkg::dma_res_t                  result,
	output logic                               satFlag
);
	import dma_pkg::*;

	// ==========================================================
	// declarations
	dma_cfg_t                   cfg_r;
	logic [DATA_W-1:0]          regRdData_r;
	logic [LANES-1:0][OP_W-1:0] aR;
	logic [LANES-1:0][OP_W-1:0] bR;
	logic [LANES-1:0][OP_W-1:0] aPrev;
	logic                       vld0_r;
	logic                       vld1_r;
	logic                       vld2_r;
	logic                       outValid_r;
	logic                       sgnA0_r;
	logic                       sgnB0_r;
	logic                       sa;
	logic                       sb;
	logic [LANES-1:0]           as1_r;
	logic [LANES-1:0]           as2_r;
	logic [LANES-1:0]           asSel;
	logic [LANES-1:0][PROD_W-1:0] prod;
	logic [LANES-1:0][PROD_W-1:0] prod_r;
	logic                       pSgn1_r;
	logic                       both1_r;
	logic                       pSgn2_r;
	logic                       both2_r;
	logic [1:0][RES_W-1:0]      stage;
	logic [1:0][RES_W-1:0]      stage_r;
	logic [RES_W-1:0]           finLo;
	logic [RES_W-1:0]           finHi;
	logic [RES_W:0]             rLo;
	logic [RES_W:0]             rHi;
	logic                       rndOn;
	dma_res_t                   result_r;
	logic                       satFlag_r;

	// ==========================================================
	// helpers
	function automatic logic isFour(input dma_mode_t m);
		case (m)
			MODE_FOUR: return 1'b1;
			MODE_FIR:  return 1'b1;
			default:   return 1'b0;
		endcase
	endfunction

	function automatic logic [RES_W-1:0] sx19(input logic [HSUM_W-1:0] v, input logic s);
		return {{(RES_W-HSUM_W){s & v[HSUM_W-1]}}, v};
	endfunction

	// round half up at the Q1.15 point, then clamp to 16 signed bits
	function automatic logic [RES_W:0] rndSat(input logic [RES_W-1:0] v);
		logic [RES_W-1:0] t;
		logic [RES_W-1:0] sh;
		t  = v + RND_HALF;
		sh = RES_W'($signed(t) >>> RND_SHIFT);
		if ($signed(sh) > $signed(SAT_MAX)) begin
			return {1'b1, SAT_MAX};
		end else if ($signed(sh) < $signed(SAT_MIN)) begin
			return {1'b1, SAT_MIN};
		end
		return {1'b0, sh};
	endfunction

	// ==========================================================
	// register port
	// control register; the block reads it live, so change it only when idle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_r <= dma_cfg_t'(CTRL_RST);
		end else if (ce && regWr && regAddr == CTRL_OFS) begin
			cfg_r <= dma_cfg_t'(regWrData[CTRL_W-1:0]);
		end
	end

	// read data one cycle after the strobe, zero for unmapped offsets
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdData_r <= '0;
		end else if (ce) begin
			regRdData_r <= '0;
			if (regRd && regAddr == CTRL_OFS) begin
				regRdData_r[CTRL_W-1:0] <= cfg_r;
			end else if (regRd && regAddr == STAT_OFS) begin
				regRdData_r[STAT_VALID_BIT] <= outValid_r;
				regRdData_r[STAT_SAT_BIT]   <= satFlag_r;
				regRdData_r[STAT_FOUR_BIT]  <= isFour(cfg_r.mode);
			end
		end
	end

	// ==========================================================
	// input stage: operand registers, FIR shift line on A
	// upstream neighbour of each tap; lane 0 takes the fabric input, so no index underflows
	assign aPrev = {aR[LANES-2:0], opIn.a[0]};

	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : gIn
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					aR[gi] <= '0;
					bR[gi] <= '0;
				end else if (ce) begin
					bR[gi] <= opIn.b[gi]; // RULE15
					if (cfg_r.mode == MODE_FIR) begin
						aR[gi] <= aPrev[gi]; // RULE15
					end else begin
						aR[gi] <= opIn.a[gi];
					end
				end
			end
		end
	endgenerate

	// last tap of the line goes out so the fabric can cascade blocks
	assign shiftOut = aR[LANES-1]; // RULE17

	// signs taken with the operands or used live one cycle later
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sgnA0_r <= 1'b0;
			sgnB0_r <= 1'b0;
		end else if (ce) begin
			sgnA0_r <= signA;
			sgnB0_r <= signB;
		end
	end

	assign sa = cfg_r.signReg ? sgnA0_r : signA; // RULE6
	assign sb = cfg_r.signReg ? sgnB0_r : signB; // RULE6

	// add/subtract select, one or two stages deep
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			as1_r <= '0;
			as2_r <= '0;
		end else if (ce) begin
			as1_r <= addSub;
			as2_r <= as1_r;
		end
	end

	assign asSel = cfg_r.pipe2 ? as2_r : as1_r; // RULE5 RULE19

	// ==========================================================
	// multiplier stage
	generate
		for (gi = 0; gi < LANES; gi++) begin : gMul
			dma_mult_lane uMul (
				.a    (aR[gi]),
				.b    (bR[gi]),
				.sa   (sa),
				.sb   (sb),
				.nine (cfg_r.nine),
				.prod (prod[gi])
			);
		end
	endgenerate

	// product pipeline register, signedness follows the data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prod_r  <= '0;
			pSgn1_r <= 1'b0;
			both1_r <= 1'b0;
		end else if (ce) begin
			prod_r  <= prod;
			pSgn1_r <= sa | sb;
			both1_r <= sa & sb;
		end
	end

	// ==========================================================
	// first adder stage: only products reach it
	generate
		for (gi = 0; gi < 2; gi++) begin : gAdd
			dma_add_stage uAdd (
				.p0      (prod_r[2*gi]),   // RULE2 RULE8
				.p1      (prod_r[2*gi+1]),
				.pSigned (pSgn1_r),
				.nine    (cfg_r.nine),
				.subLo   (asSel[2*gi]),
				.subHi   (asSel[2*gi+1]),
				.sum     (stage[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage_r <= '0;
			pSgn2_r <= 1'b0;
			both2_r <= 1'b0;
		end else if (ce) begin
			stage_r <= stage; // RULE1
			pSgn2_r <= pSgn1_r;
			both2_r <= both1_r;
		end
	end

	// ==========================================================
	// final summation and rounding
	// two-product results pass this stage too, keeping one latency for all modes
	always_comb begin
		if (isFour(cfg_r.mode)) begin
			if (cfg_r.nine) begin
				finLo = sx19(stage_r[0][HSUM_W-1:0], pSgn2_r)
				      + sx19(stage_r[1][HSUM_W-1:0], pSgn2_r); // RULE11
				finHi = sx19(stage_r[0][RES_W-1:HSUM_W], pSgn2_r)
				      + sx19(stage_r[1][RES_W-1:HSUM_W], pSgn2_r);
			end else begin
				finLo = stage_r[0] + stage_r[1]; // RULE12
				finHi = '0;
			end
		end else begin
			finLo = stage_r[0];
			finHi = stage_r[1];
		end
		rLo = rndSat(finLo);
		rHi = rndSat(finHi);
	end

	assign rndOn = cfg_r.rndEn && !cfg_r.nine && both2_r; // RULE14

	// output registers with their matching valid
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			result_r  <= '0;
			satFlag_r <= 1'b0;
		end else if (ce) begin
			result_r.lo <= rndOn ? rLo[RES_W-1:0] : finLo;
			result_r.hi <= rndOn ? rHi[RES_W-1:0] : finHi;
			satFlag_r   <= rndOn && (rLo[RES_W] || rHi[RES_W]); // RULE14
		end
	end

	// valid rides beside the data, one flop per data stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vld0_r     <= 1'b0;
			vld1_r     <= 1'b0;
			vld2_r     <= 1'b0;
			outValid_r <= 1'b0;
		end else if (ce) begin
			vld0_r     <= inValid;
			vld1_r     <= vld0_r;
			vld2_r     <= vld1_r;
			outValid_r <= vld2_r; // RULE7
		end
	end

	assign regRdData = regRdData_r;
	assign outValid  = outValid_r;
	assign result    = result_r;
	assign satFlag   = satFlag_r;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_valid_latency: assert property ((ce && inValid) ##1 ce[*3] |=> outValid_r) // RULE7
		else $error("valid did not follow data latency");

	a_sub_order: assert property ( // RULE20
		(ce && !cfg_r.nine && asSel[0] && !pSgn1_r) |=>
		stage_r[0] == ({2'b00, $past(prod_r[0])} - {2'b00, $past(prod_r[1])}))
		else $error("subtract order wrong");

	a_nine_split: assert property ( // RULE3
		(ce && cfg_r.nine && !asSel[1] && !pSgn1_r) |=>
		stage_r[0][RES_W-1:HSUM_W] == ({1'b0, $past(prod_r[0][PROD_W-1:HPROD_W])}
		                             + {1'b0, $past(prod_r[1][PROD_W-1:HPROD_W])})) // RULE3
		else $error("upper 9-bit sum wrong");

	a_four_sum: assert property ( // RULE12
		(ce && isFour(cfg_r.mode) && !cfg_r.nine && !rndOn) |=>
		result_r.lo == $past(stage_r[0]) + $past(stage_r[1]))
		else $error("final summation wrong");

	a_round_only: assert property (satFlag_r |-> $past(rndOn)) // RULE14
		else $error("saturation without rounding mode");

	a_sat_range: assert property ( // RULE14
		(ce && rndOn) |=>
		($signed(result_r.lo) <= $signed(SAT_MAX) && $signed(result_r.lo) >= $signed(SAT_MIN)))
		else $error("rounded result out of range");

	a_fir_chain: assert property ( // RULE15
		(ce && cfg_r.mode == MODE_FIR) |=>
		(aR[1] == $past(aR[0]) && aR[0] == $past(opIn.a[0]) && bR[1] == $past(opIn.b[1])))
		else $error("shift line or coefficient hold wrong");

	a_pipe_two: assert property (
		(ce && cfg_r.pipe2) ##1 (ce && cfg_r.pipe2) |=> asSel == $past(addSub, 2)) // RULE5
		else $error("two-stage select misaligned");

	a_ctrl_read: assert property (
		(ce && regRd && regAddr == CTRL_OFS) |=> regRdData_r == DATA_W'($past(cfg_r)))
		else $error("control readback wrong");

	c_four_out: cover property (outValid_r && isFour(cfg_r.mode));
	c_fir_out:  cover property (outValid_r && cfg_r.mode == MODE_FIR);
	c_sat:      cover property (satFlag_r);
	c_sub_two:  cover property (ce && cfg_r.mode == MODE_TWO && asSel[0] && vld1_r);

endmodule

/* File: design/dma_mult_lane.sv */
`timescale 1ns/100ps
// one multiplier lane: an 18x18 product or two packed 9x9 products
module dma_mult_lane (
	input  wire logic [dma_pkg::OP_W-1:0]   a,
	input  wire logic [dma_pkg::OP_W-1:0]   b,
	input  wire logic                       sa,
	input  wire logic                       sb,
	input  wire logic                       nine,
	output logic      [dma_pkg::PROD_W-1:0] prod
);
	import dma_pkg::*;

	logic signed [2*OP_W+1:0]   full;
	logic signed [2*HALF_W+1:0] lo;
	logic signed [2*HALF_W+1:0] hi;

	// each operand widened by its own sign control
	always_comb begin
		full = $signed({sa & a[OP_W-1], a}) * $signed({sb & b[OP_W-1], b}); // RULE18
		lo   = $signed({sa & a[HALF_W-1], a[HALF_W-1:0]})
		     * $signed({sb & b[HALF_W-1], b[HALF_W-1:0]});
		hi   = $signed({sa & a[OP_W-1], a[OP_W-1:HALF_W]})
		     * $signed({sb & b[OP_W-1], b[OP_W-1:HALF_W]});
		prod = nine ? {hi[HPROD_W-1:0], lo[HPROD_W-1:0]} : full[PROD_W-1:0]; // RULE9
	end

endmodule

/* File: design/dma_pkg.sv */
// Contract
// RULE1: multiply-add mode routes products to adder, adding or subtracting two or four.
// RULE2: the adder stage takes inputs only from the multiplier products.
// RULE3: two-product mode gives four 9-bit adders or two 18-bit adders.
// RULE4: each two-product adder gives sum or difference, chosen live by fabric.
// RULE5: add/subtract controls pass through one or two pipeline stages, configurable.
// RULE6: sign controls are used unregistered or registered once with operands.
// RULE7: output-side control carries the same latency as the result data.
// RULE8: 18-bit complex multiply: real a*c minus b*d, imaginary a*d plus b*c.
// RULE9: 9-bit operands allow two complex products on eight small multipliers.
// RULE10: fabric steers real and imaginary parts onto the right multiplier inputs.
// RULE11: four-product sum in two stages, one 18-bit or two 9-bit adders.
// RULE12: two first-stage adders each combine two products, a final stage adds them.
// RULE13: fabric should pipeline adder controls in four-product mode to match data.
// RULE14: round and saturate only for signed 18-bit Q1.15 products.
// RULE15: FIR mode chains operand A registers as a shift line, B holds coefficients.
// RULE16: full 36-bit multiplication needs external shift registers, the chain is absent.
// RULE17: one block is a four-tap 18-bit FIR, longer filters cascade outside.
// RULE18: each operand is signed or unsigned by its own live sign control.
// RULE19: a live add/subtract select chooses add or subtract in the adder stage.
// RULE20: subtraction always yields first product minus second product.
package dma_pkg;

	// ==========================================================
	// widths
	localparam int OP_W    = 18;
	localparam int HALF_W  = 9;
	localparam int PROD_W  = 36;
	localparam int HPROD_W = 18;
	localparam int RES_W   = 38;
	localparam int HSUM_W  = 19;
	localparam int LANES   = 4;
	localparam int DATA_W  = 32;
	localparam int ADDR_W  = 4;
	localparam int CTRL_W  = 6;

	// ==========================================================
	// register map
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_SAT_BIT   = 1;
	localparam int STAT_FOUR_BIT  = 2;

	// ==========================================================
	// fixed-point rounding, Q1.15 products land as Q2.30
	localparam int RND_SHIFT = 15;
	localparam logic [RES_W-1:0] RND_HALF = 38'h0000004000;
	localparam logic [RES_W-1:0] SAT_MAX  = 38'h0000007fff;
	localparam logic [RES_W-1:0] SAT_MIN  = 38'h3fffff8000;

	// ==========================================================
	// modes and carriers
	typedef enum logic [1:0] {
		MODE_TWO  = 2'b00,
		MODE_FOUR = 2'b01,
		MODE_FIR  = 2'b10
	} dma_mode_t;

	typedef struct packed {
		logic      rndEn;
		logic      signReg;
		logic      pipe2;
		logic      nine;
		dma_mode_t mode;
	} dma_cfg_t;

	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h18;

	typedef struct packed {
		logic [LANES-1:0][OP_W-1:0] a;
		logic [LANES-1:0][OP_W-1:0] b;
	} dma_ops_t;

	typedef struct packed {
		logic [RES_W-1:0] hi;
		logic [RES_W-1:0] lo;
	} dma_res_t;

endpackage

/* File: tb/dma_fabric_model.sv */
`timescale 1ns/100ps
// =====================================
// fabric side: operands, signs and add/subtract selects
module dma_fabric_model (
	input  wire logic                 clk,
	output dma_pkg::dma_ops_t         opIn,
	output logic                      inValid,
	output logic                      signA,
	output logic                      signB,
	output logic [dma_pkg::LANES-1:0] addSub
);
	import dma_pkg::*;
	logic [LANES-1:0] subLate;
	logic             lateOn;

	// quiet at time zero
	initial begin
		opIn = '0;
		inValid = 1'b0;
		signA = 1'b1;
		signB = 1'b1;
		addSub = '0;
		subLate = '0;
		lateOn = 1'b0;
	end

	// one sample per call; the caller steers real/imag parts onto lanes
	task automatic put(input dma_ops_t ops, input logic sa, input logic sb,
		input logic [LANES-1:0] sub, input logic late);
		@(posedge clk);
		opIn <= ops;
		inValid <= 1'b1;
		signA <= sa;
		signB <= sb;
		// a late select shows the wrong value first, so early sampling fails
		addSub <= late ? ~sub : sub;
		subLate = sub;
		lateOn = late;
	endtask

	// released lines flip so a stale capture cannot pass
	task automatic idle();
		@(posedge clk);
		inValid <= 1'b0;
		opIn <= ~opIn;
		signA <= ~signA;
		signB <= ~signB;
		addSub <= lateOn ? subLate : ~addSub;
		lateOn = 1'b0;
	endtask
endmodule

/* File: tb/dma_mult_add_tb_top.sv */
`timescale 1ns/100ps
module dma_mult_add_tb_top;
	import dma_pkg::*;
	logic              clk;
	logic              sysRst;
	logic              ce;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData;
	logic              regWr;
	logic              regRd;
	logic [DATA_W-1:0] regRdData;
	logic              inValid;
	dma_ops_t          opIn;
	logic              signA;
	logic              signB;
	logic [LANES-1:0]  addSub;
	logic [OP_W-1:0]   shiftOut;
	logic              outValid;
	dma_res_t          result;
	logic              satFlag;
	logic [DATA_W-1:0] rdVal;
	dma_ops_t          cx;
	int                miscompares;
	int                comparisons;
	int                cycles;

	dma_mult_add u_dma_mult_add (
		.clk(clk), .sys_rst(sysRst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .inValid(inValid),
		.opIn(opIn), .signA(signA), .signB(signB), .addSub(addSub),
		.shiftOut(shiftOut), .outValid(outValid), .result(result), .satFlag(satFlag)
	);

	dma_fabric_model u_dma_fabric_model (
		.clk(clk), .opIn(opIn), .inValid(inValid), .signA(signA), .signB(signB),
		.addSub(addSub)
	);

	// =====================================
	// clock and hang guard
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// the run needs about a hundred cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			final_report();
		end
	end

	// =====================================
	// helpers
	task automatic final_report();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chkWord(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkRes(input dma_res_t got, input dma_res_t exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic regRead(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask

	function automatic dma_ops_t ops4(input logic [OP_W-1:0] a0, a1, a2, a3, b0, b1, b2, b3);
		ops4.a = {a3, a2, a1, a0};
		ops4.b = {b3, b2, b1, b0};
	endfunction

	function automatic logic [RES_W-1:0] sx(input longint v);
		return RES_W'(v);
	endfunction

	// one sample in, result looked at exactly four edges later
	task automatic run(input dma_ops_t o, input logic s, input logic [LANES-1:0] sub,
		input logic late, input dma_res_t e, input logic eSat);
		u_dma_fabric_model.put(o, s, s, sub, late);
		u_dma_fabric_model.idle();
		repeat (3) @(posedge clk);
		#1;
		chkWord({31'h0, outValid}, 32'h1);
		chkRes(result, e);
		chkWord({31'h0, satFlag}, {31'h0, eSat});
	endtask

	// =====================================
	// test sequence
	initial begin
		sysRst = 1'b1;
		ce = 1'b1;
		regAddr = '0;
		regWrData = '0;
		regWr = 1'b0;
		regRd = 1'b0;
		miscompares = 0;
		comparisons = 0;
		cycles = 0;
		repeat (4) @(posedge clk);
		sysRst <= 1'b0;

		// control defaults, status, unmapped places
		regRead(CTRL_OFS, rdVal);
		chkWord(rdVal, 32'h18);
		regRead(STAT_OFS, rdVal);
		chkWord(rdVal, 32'h0);
		regWrite(4'h8, 32'h3f);
		regRead(4'h8, rdVal);
		chkWord(rdVal, 32'h0);
		regRead(CTRL_OFS, rdVal);
		chkWord(rdVal, 32'h18);
		$display("test regs done");

		// complex product: real a*c-b*d low, imag a*d+b*c high
		cx = ops4(18'h3, 18'h5, 18'h3, 18'h5, 18'h4, 18'h6, 18'h6, 18'h4);
		run(cx, 1'b1, 4'h1, 1'b0, {sx(38), sx(-18)}, 1'b0);
		run(cx, 1'b1, 4'h4, 1'b0, {sx(-2), sx(42)}, 1'b0);
		run(ops4(18'h3ffff, 18'h1, 18'h0, 18'h0, 18'h2, 18'h1, 18'h0, 18'h0), 1'b0, 4'h0,
			1'b0, {sx(0), 38'h7ffff}, 1'b0);
		// enable low for two edges holds every stage, so the answer comes two edges late
		u_dma_fabric_model.put(cx, 1'b1, 1'b1, 4'h1, 1'b0);
		u_dma_fabric_model.idle();
		@(posedge clk);
		ce <= 1'b0;
		repeat (2) @(posedge clk);
		ce <= 1'b1;
		#1;
		chkWord({31'h0, outValid}, 32'h0);
		repeat (2) @(posedge clk);
		#1;
		chkWord({31'h0, outValid}, 32'h1);
		chkRes(result, {sx(38), sx(-18)});
		$display("test two18 done");

		// select taken one stage later with a single pipeline register
		regWrite(CTRL_OFS, 32'h10);
		run(cx, 1'b1, 4'h1, 1'b1, {sx(38), sx(-18)}, 1'b0);
		$display("test pipe1 done");

		// four packed 9-bit adders, each half with its own select
		regWrite(CTRL_OFS, 32'h1c);
		run(ops4({9'd2, 9'd3}, {9'd1, 9'd1}, {9'd1, 9'd2}, 18'h0, {9'd4, 9'd5}, {9'd1, 9'd1},
			{9'd1, 9'd2}, 18'h0), 1'b1, 4'h1, 1'b0,
			{19'd1, 19'd4, 19'd9, 19'd14}, 1'b0);
		$display("test two9 done");

		// four-product sums in two stages
		regWrite(CTRL_OFS, 32'h19);
		run(ops4(18'h1, 18'h2, 18'h3, 18'h4, 18'h5, 18'h6, 18'h7, 18'h8), 1'b1, 4'h4, 1'b0,
			{sx(0), sx(6)}, 1'b0);
		regWrite(CTRL_OFS, 32'h1d);
		run(dma_ops_t'({{4{9'd3, 9'd1}}, {4{9'd1, 9'd2}}}), 1'b1, 4'h0, 1'b0,
			{sx(12), sx(8)}, 1'b0);
		$display("test four done");

		// shift chain on lane 0, other a lanes carry junk that must be ignored;
		// only the narrow modes run here, so the fabric never needs a shift line of its own
		regWrite(CTRL_OFS, 32'h1a);
		for (int i = 0; i < 4; i++) begin
			u_dma_fabric_model.put(ops4(18'(10 * (i + 1)), 18'h155, 18'h2aa, 18'h155, 18'h1,
				18'h2, 18'h4, 18'h8), 1'b1, 1'b1, 4'h0, 1'b0);
		end
		u_dma_fabric_model.idle();
		repeat (3) @(posedge clk);
		#1;
		chkRes(result, {sx(0), sx(260)});
		// the newest of the four samples now stands at the end of the line
		chkWord({14'h0, shiftOut}, 32'h28);
		$display("test fir done");

		// rounding, clamping, and no rounding when unsigned
		regWrite(CTRL_OFS, 32'h38);
		run(ops4(18'h4000, 18'h0, 18'h0, 18'h0, 18'h4000, 18'h0, 18'h0, 18'h0), 1'b1, 4'h0,
			1'b0, {sx(0), sx(32'h2000)}, 1'b0);
		run(ops4(18'h38000, 18'h38000, 18'h0, 18'h0, 18'h38000, 18'h38000, 18'h0, 18'h0),
			1'b1, 4'h0, 1'b0, {sx(0), sx(32'h7fff)}, 1'b1);
		run(ops4(18'h4000, 18'h0, 18'h0, 18'h0, 18'h4000, 18'h0, 18'h0, 18'h0), 1'b0, 4'h0,
			1'b0, {sx(0), 38'h10000000}, 1'b0);
		$display("test round done");

		// signs used live: they arrive one cycle after the operands, idle flips them to 1
		regWrite(CTRL_OFS, 32'h08);
		u_dma_fabric_model.put(ops4(18'h3ffff, 18'h1, 18'h0, 18'h0, 18'h2, 18'h1, 18'h0, 18'h0),
			1'b0, 1'b0, 4'h0, 1'b0);
		u_dma_fabric_model.idle();
		repeat (3) @(posedge clk);
		#1;
		chkRes(result, {sx(0), sx(-1)});
		$display("test live sign done");

		final_report();
	end
endmodule
